// File: core/ovuvf_divider.sv
`timescale 1ns/100ps
module ovuvf_divider (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic start,
	input wire logic [ovuvf_pkg::DIV_W-1:0] dividend,
	input wire logic [ovuvf_pkg::DIV_W-1:0] divisor,
	output logic busy,
	output logic done,
	output logic [ovuvf_pkg::DIV_W-1:0] quotient
);
	import ovuvf_pkg::*;
	// restoring divider, one quotient bit per cycle; a zero divisor yields all ones
	ovuvf_div_e state_reg;
	logic [DIV_W-1:0] rem_reg;
	logic [DIV_W-1:0] quo_reg;
	logic [DIV_W-1:0] dvs_reg;
	logic [DIV_CNT_W-1:0] cnt_reg;
	wire [DIV_W:0] trial = {rem_reg, quo_reg[DIV_W-1]};
	wire fits = trial >= {1'b0, dvs_reg};
	wire [DIV_W:0] trial_sub = trial - {1'b0, dvs_reg};
	wire [DIV_W-1:0] rem_next = fits ? trial_sub[DIV_W-1:0] : trial[DIV_W-1:0];
	wire [DIV_W-1:0] quo_next = {quo_reg[DIV_W-2:0], fits};

	assign busy = state_reg == DIV_RUN;
	assign done = state_reg == DIV_DONE;
	assign quotient = quo_reg;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_reg <= DIV_IDLE;
			rem_reg <= '0;
			quo_reg <= '0;
			dvs_reg <= '0;
			cnt_reg <= '0;
		end else if (ce) begin
			case (state_reg)
				DIV_IDLE: begin
					if (start) begin
						rem_reg <= '0;
						quo_reg <= dividend;
						dvs_reg <= divisor;
						cnt_reg <= '0;
						state_reg <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					rem_reg <= rem_next;
					quo_reg <= quo_next;
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == 5'(DIV_W - 1)) begin
						state_reg <= DIV_DONE;
					end
				end
				DIV_DONE: state_reg <= DIV_IDLE;
				default: state_reg <= DIV_IDLE;
			endcase
		end
	end
endmodule

// File: core/ovuvf_pkg.sv
package ovuvf_pkg;
	// command codes of the four configuration registers
	localparam logic [7:0] CMD_OVUV_CFG = 8'hD8;
	localparam logic [7:0] CMD_TEMP_SCALE = 8'hD9;
	localparam logic [7:0] CMD_TEMP_OFFSET = 8'hDA;
	localparam logic [7:0] CMD_ALERT_MASK = 8'hDB;
	// transfer lengths in bytes; a block carries its count byte first
	localparam int LEN_BYTE = 1;
	localparam int LEN_WORD = 2;
	localparam int MASK_BYTES = 7;
	localparam int LEN_BLOCK = MASK_BYTES + 1;
	localparam int BUF_IDX_W = 4;
	// ovuv_fault_config fields
	localparam int CFG_COUNT_LSB = 0;
	localparam int CFG_COUNT_W = 4;
	localparam int CFG_CROWBAR_BIT = 7;
	// reset values
	localparam logic [7:0] OVUV_CFG_RST = 8'h00;
	localparam logic [15:0] TEMP_SCALE_RST = 16'h0001;
	localparam logic [15:0] TEMP_OFFSET_RST = 16'h0000;
	localparam logic [55:0] ALERT_MASK_RST = 56'h0;
	localparam logic [7:0] UNMAPPED_BYTE = 8'hFF;
	// status bit positions within the 56-bit status image
	localparam int ST_VOUT_OV = 7;
	localparam int ST_VOUT_UV = 4;
	localparam int ST_TEMP_EXT1 = 25;
	localparam int ST_TEMP_EXT0 = 26;
	localparam int ST_TEMP_INT = 27;
	localparam int ST_OTHER_COMM = 33;
	localparam int ST_PEC_FAIL = 37;
	localparam int ST_INV_DATA = 38;
	localparam int ST_INV_CMD = 39;
	localparam int ST_VOLTAGE_MONITOR_OV_FLT = 48;
	localparam int ST_VOLTAGE_MONITOR_UV_FLT = 49;
	localparam int ST_GROUP_FLT = 50;
	localparam int ST_TSW_FLT = 51;
	localparam int ST_VOLTAGE_MONITOR_OV_WARN = 52;
	localparam int ST_VOLTAGE_MONITOR_UV_WARN = 53;
	localparam int ST_GCB_FLT = 54;
	localparam int ST_INIT_FLT = 55;
	// monitor warning thresholds in percent of the fault limit
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] VOLTAGE_MONITOR_UV_WARN_PCT = 8'h6E;
	localparam logic [7:0] VOLTAGE_MONITOR_OV_WARN_PCT = 8'h5F;
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SYNC_LOSS_NS = 10000;
	localparam int SYNC_LOSS_CYCLES = (SYNC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CNT_W = $clog2(SYNC_LOSS_CYCLES + 1);
	localparam int DIV_W = 16;
	localparam int DIV_CNT_W = 5;
	// sticky event flags kept by this block
	localparam int EV_INV_CMD = 0;
	localparam int EV_INV_DATA = 1;
	localparam int EV_PEC = 2;
	localparam int EV_OTHER = 3;
	localparam int EV_VOUT_OV = 4;
	localparam int EV_VOUT_UV = 5;
	localparam int EV_TSW = 6;
	localparam int EV_N = 7;
	typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_DONE} ovuvf_div_e;
endpackage

// File: core/ovuvf_top.sv
`timescale 1ns/100ps
module ovuvf_top (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tx_start,
	input wire logic [7:0] tx_code,
	input wire logic tx_end,
	input wire logic wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic rd_req,
	output logic rd_valid,
	output logic [7:0] rd_byte,
	input wire logic pec_fail,
	input wire logic protected_wr,
	input wire logic comm_fault_other,
	input wire logic clear_status,
	input wire logic sample_valid,
	input wire logic ov_viol,
	input wire logic uv_viol,
	output logic lowside_on,
	input wire logic temp_valid,
	input wire logic [ovuvf_pkg::DIV_W-1:0] temp_meas,
	output logic temp_report_valid,
	output logic [15:0] temp_report,
	input wire logic voltage_monitor_valid,
	input wire logic [15:0] voltage_monitor,
	input wire logic [15:0] voltage_monitor_uv_limit,
	input wire logic [15:0] voltage_monitor_ov_limit,
	input wire logic sync_en,
	input wire logic sync_clk_pin,
	input wire logic [55:0] status_in,
	output logic [55:0] status_image,
	output logic alert_output
);
	import ovuvf_pkg::*;

	// configuration registers
	logic [7:0] ovuv_fault_config_reg;
	logic [15:0] ext_temp_scale_reg;
	logic [15:0] ext_temp_offset_reg;
	logic [55:0] alert_mask_block_reg;

	// command transaction state
	logic [7:0] code_reg;
	logic known_reg;
	logic [BUF_IDX_W-1:0] wr_idx_reg;
	logic [BUF_IDX_W-1:0] rd_idx_reg;
	logic overrun_reg;
	logic [7:0] buf_reg [0:LEN_BLOCK-1];

	wire code_known = tx_code == CMD_OVUV_CFG || tx_code == CMD_TEMP_SCALE ||
		tx_code == CMD_TEMP_OFFSET || tx_code == CMD_ALERT_MASK;
	wire is_cfg = code_reg == CMD_OVUV_CFG;
	wire is_scale = code_reg == CMD_TEMP_SCALE;
	wire is_offset = code_reg == CMD_TEMP_OFFSET;
	wire is_mask = code_reg == CMD_ALERT_MASK;
	wire wrote_any = wr_idx_reg != '0;
	wire len_ok = (is_cfg && wr_idx_reg == BUF_IDX_W'(LEN_BYTE)) ||
		((is_scale || is_offset) && wr_idx_reg == BUF_IDX_W'(LEN_WORD)) ||
		(is_mask && wr_idx_reg == BUF_IDX_W'(LEN_BLOCK) && buf_reg[0] == 8'(MASK_BYTES));
	wire commit = ce && tx_end && known_reg && wrote_any && len_ok && !overrun_reg;
	wire bad_data = ce && tx_end && known_reg && wrote_any && (!len_ok || overrun_reg);
	wire bad_cmd = ce && tx_start && !code_known;

	// mask bytes are stored in transfer order, byte 0 lowest
	logic [55:0] mask_wr;
	genvar gi;
	generate
		for (gi = 0; gi < MASK_BYTES; gi++) begin : g_mask
			assign mask_wr[gi*8 +: 8] = buf_reg[gi+1];
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			code_reg <= 8'h00;
			known_reg <= 1'b0;
			wr_idx_reg <= '0;
			overrun_reg <= 1'b0;
			for (int i = 0; i < LEN_BLOCK; i++) begin
				buf_reg[i] <= 8'h00;
			end
		end else if (ce) begin
			if (tx_start) begin
				code_reg <= tx_code;
				known_reg <= code_known;
				wr_idx_reg <= '0;
				overrun_reg <= 1'b0;
			end else if (wr_valid && known_reg) begin
				if (wr_idx_reg == BUF_IDX_W'(LEN_BLOCK)) begin
					overrun_reg <= 1'b1;
				end else begin
					buf_reg[wr_idx_reg[2:0]] <= wr_byte;
					wr_idx_reg <= wr_idx_reg + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ovuv_fault_config_reg <= OVUV_CFG_RST;
			ext_temp_scale_reg <= TEMP_SCALE_RST;
			ext_temp_offset_reg <= TEMP_OFFSET_RST;
			alert_mask_block_reg <= ALERT_MASK_RST;
		end else if (commit) begin
			if (is_cfg) ovuv_fault_config_reg <= buf_reg[0];
			if (is_scale) ext_temp_scale_reg <= {buf_reg[1], buf_reg[0]};
			if (is_offset) ext_temp_offset_reg <= {buf_reg[1], buf_reg[0]};
			if (is_mask) alert_mask_block_reg <= mask_wr;
		end
	end

	// read side: words low byte first, the block opens with its byte count
	wire [7:0] mask_rd_byte = rd_idx_reg == '0 ? 8'(MASK_BYTES) :
		rd_idx_reg > BUF_IDX_W'(MASK_BYTES) ? UNMAPPED_BYTE :
		alert_mask_block_reg[(rd_idx_reg - 4'h1)*8 +: 8];
	wire [15:0] word_rd = is_scale ? ext_temp_scale_reg : ext_temp_offset_reg;
	wire [7:0] word_rd_byte = rd_idx_reg == '0 ? word_rd[7:0] :
		rd_idx_reg == 4'h1 ? word_rd[15:8] : UNMAPPED_BYTE;
	wire [7:0] rd_sel = !known_reg ? UNMAPPED_BYTE :
		is_mask ? mask_rd_byte :
		is_cfg ? (rd_idx_reg == '0 ? ovuv_fault_config_reg : UNMAPPED_BYTE) : word_rd_byte;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rd_idx_reg <= '0;
			rd_valid <= 1'b0;
			rd_byte <= 8'h00;
		end else if (ce) begin
			rd_valid <= rd_req && !tx_start;
			if (tx_start) begin
				rd_idx_reg <= '0;
			end else if (rd_req) begin
				rd_byte <= rd_sel;
				if (rd_idx_reg != 4'hF) rd_idx_reg <= rd_idx_reg + 4'h1;
			end
		end
	end

	// debounce of output over- and under-voltage, channel 0 is over-voltage
	wire [CFG_COUNT_W-1:0] cfg_count = ovuv_fault_config_reg[CFG_COUNT_LSB +: CFG_COUNT_W];
	wire [1:0] viol = {uv_viol, ov_viol};
	logic [CFG_COUNT_W-1:0] run_reg [0:1];
	logic [1:0] hit;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_deb
			// the run saturates at the field maximum, not at the count, so a lowered count acts at once
			assign hit[gi] = sample_valid && viol[gi] && run_reg[gi] >= cfg_count;
			always_ff @(posedge ref_clk) begin
				if (!resetn) begin
					run_reg[gi] <= '0;
				end else if (ce && sample_valid) begin
					if (!viol[gi]) begin
						run_reg[gi] <= '0;
					end else if (run_reg[gi] != {CFG_COUNT_W{1'b1}}) begin
						run_reg[gi] <= run_reg[gi] + 4'h1;
					end
				end
			end
		end
	endgenerate

	// independent run count for the debounce checks, one bit wider than the field
	logic [CFG_COUNT_W:0] ov_run_chk_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ov_run_chk_reg <= '0;
		end else if (ce && sample_valid) begin
			if (!ov_viol) begin
				ov_run_chk_reg <= '0;
			end else if (!ov_run_chk_reg[CFG_COUNT_W]) begin
				ov_run_chk_reg <= ov_run_chk_reg + 5'h01;
			end
		end
	end

	// external sync watchdog; the first sync stage feeds only the second
	logic sync_s1_reg;
	logic sync_s2_reg;
	logic sync_s3_reg;
	logic [SYNC_CNT_W-1:0] sync_cnt_reg;
	wire sync_edge = sync_s2_reg && !sync_s3_reg;
	wire sync_lost = sync_en && !sync_edge && sync_cnt_reg == SYNC_CNT_W'(SYNC_LOSS_CYCLES - 1);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			sync_s3_reg <= 1'b0;
			sync_cnt_reg <= '0;
		end else if (ce) begin
			sync_s1_reg <= sync_clk_pin;
			sync_s2_reg <= sync_s1_reg;
			sync_s3_reg <= sync_s2_reg;
			if (!sync_en || sync_edge) begin
				sync_cnt_reg <= '0;
			end else if (sync_cnt_reg != SYNC_CNT_W'(SYNC_LOSS_CYCLES)) begin
				sync_cnt_reg <= sync_cnt_reg + 1'b1;
			end
		end
	end

	// sticky events: a new event in the clearing cycle survives the clear
	logic [EV_N-1:0] ev_reg;
	wire [EV_N-1:0] ev_set;
	assign ev_set[EV_INV_CMD] = bad_cmd;
	assign ev_set[EV_INV_DATA] = bad_data;
	assign ev_set[EV_PEC] = pec_fail;
	assign ev_set[EV_OTHER] = protected_wr || comm_fault_other;
	assign ev_set[EV_VOUT_OV] = hit[0];
	assign ev_set[EV_VOUT_UV] = hit[1];
	assign ev_set[EV_TSW] = sync_lost;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ev_reg <= '0;
			lowside_on <= 1'b0;
		end else if (ce) begin
			ev_reg <= (ev_reg & {EV_N{!clear_status}}) | ev_set;
			lowside_on <= ev_reg[EV_VOUT_OV] && ovuv_fault_config_reg[CFG_CROWBAR_BIT];
		end
	end

	// monitor warnings, evaluated in percent without a divider
	wire [23:0] voltage_monitor_pct = voltage_monitor * PCT_FULL;
	wire [23:0] uv_warn_lim = voltage_monitor_uv_limit * VOLTAGE_MONITOR_UV_WARN_PCT;
	wire [23:0] ov_warn_lim = voltage_monitor_ov_limit * VOLTAGE_MONITOR_OV_WARN_PCT;
	wire uv_warn_now = voltage_monitor_pct < uv_warn_lim;
	wire ov_warn_now = voltage_monitor_pct > ov_warn_lim;
	logic uv_warn_reg;
	logic ov_warn_reg;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			uv_warn_reg <= 1'b0;
			ov_warn_reg <= 1'b0;
		end else if (ce && voltage_monitor_valid) begin
			uv_warn_reg <= uv_warn_now;
			ov_warn_reg <= ov_warn_now;
		end
	end

	// status image: bits this block owns are ored over the device inputs
	logic [55:0] own_bits;
	always_comb begin
		own_bits = '0;
		own_bits[ST_VOUT_OV] = ev_reg[EV_VOUT_OV];
		own_bits[ST_VOUT_UV] = ev_reg[EV_VOUT_UV];
		own_bits[ST_OTHER_COMM] = ev_reg[EV_OTHER];
		own_bits[ST_PEC_FAIL] = ev_reg[EV_PEC];
		own_bits[ST_INV_DATA] = ev_reg[EV_INV_DATA];
		own_bits[ST_INV_CMD] = ev_reg[EV_INV_CMD];
		own_bits[ST_TSW_FLT] = ev_reg[EV_TSW];
		own_bits[ST_VOLTAGE_MONITOR_OV_WARN] = ov_warn_reg;
		own_bits[ST_VOLTAGE_MONITOR_UV_WARN] = uv_warn_reg;
	end
	// bits 55, 54, 50, 49, 48, 27..25 arrive on status_in at their mask positions
	wire [55:0] status_all = status_in | own_bits;
	wire [55:0] unmasked = status_all & ~alert_mask_block_reg;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			status_image <= '0;
			alert_output <= 1'b0;
		end else if (ce) begin
			status_image <= status_all;
			alert_output <= |unmasked;
		end
	end

	// external temperature report; divider runs 16 cycles, samples arriving while it is not idle are dropped
	logic div_busy;
	logic div_done;
	logic [DIV_W-1:0] div_quo;
	ovuvf_divider u_div (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.start(temp_valid),
		.dividend(temp_meas),
		.divisor(ext_temp_scale_reg),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_quo)
	);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			temp_report_valid <= 1'b0;
			temp_report <= 16'h0000;
		end else if (ce) begin
			temp_report_valid <= div_done;
			if (div_done) temp_report <= div_quo + ext_temp_offset_reg;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	fault_count_a: assert property ((ce && ev_set[EV_VOUT_OV]) |->
		(ov_viol && sample_valid && ov_run_chk_reg >= {1'b0, cfg_count}))
		else $error("over-voltage fault raised before the configured run");
	counter_restart_a: assert property ((ce && sample_valid && !uv_viol) |=> run_reg[1] == '0)
		else $error("violation counter not restarted");
	crowbar_on_a: assert property ((ce && ev_set[EV_VOUT_OV] && !clear_status) ##1 ce |=>
		(lowside_on == $past(ovuv_fault_config_reg[CFG_CROWBAR_BIT])))
		else $error("low-side switch does not follow crowbar bit");
	temp_report_a: assert property ((ce && div_done) |=>
		(temp_report_valid && temp_report == $past(div_quo) + $past(ext_temp_offset_reg)))
		else $error("temperature report wrong");
	mask_commit_a: assert property ((commit && is_mask) |=> alert_mask_block_reg == $past(mask_wr))
		else $error("alert mask block not stored");
	alert_gate_a: assert property (ce |=> alert_output == |($past(status_all) & ~$past(alert_mask_block_reg)))
		else $error("alert output disagrees with mask");
	bad_cmd_flag_a: assert property (bad_cmd ##1 ce |=> status_image[ST_INV_CMD])
		else $error("unsupported command not flagged");
	uv_warn_a: assert property ((ce && voltage_monitor_valid) |=>
		uv_warn_reg == ($past(voltage_monitor) * 24'd100 < $past(voltage_monitor_uv_limit) * 24'd110))
		else $error("monitor undervoltage warning at wrong threshold");
	sync_loss_a: assert property ((ce && sync_lost) |-> sync_cnt_reg == SYNC_CNT_W'(SYNC_LOSS_CYCLES - 1))
		else $error("sync loss flagged at wrong time");
	other_comm_a: assert property ((ce && protected_wr) |=> ev_reg[EV_OTHER])
		else $error("protected write not flagged");
	fault_run_a: assert property ((ce && sample_valid && ov_viol && ov_run_chk_reg >= {1'b0, cfg_count}) |->
		ev_set[EV_VOUT_OV])
		else $error("over-voltage fault missing after the configured run");
	mask_byte0_a: assert property ((ce && rd_req && !tx_start && is_mask && known_reg &&
		rd_idx_reg == 4'h1) |=> rd_byte == $past(alert_mask_block_reg[7:0]))
		else $error("first mask byte does not carry output voltage bits");
endmodule

// File: tb/ovuvf_host.sv
`timescale 1ns/100ps
module ovuvf_host (
	input wire logic ref_clk,
	output logic tx_start,
	output logic [7:0] tx_code,
	output logic tx_end,
	output logic wr_valid,
	output logic [7:0] wr_byte,
	output logic rd_req,
	input wire logic rd_valid,
	input wire logic [7:0] rd_byte
);
	int slow = 0;
	int to_count = 0;
	initial begin
		{tx_start, tx_end, wr_valid, rd_req} = 4'h0;
		tx_code = 8'h00;
		wr_byte = 8'h00;
	end
	// slow mode stretches the gaps between bytes the way a busy host would
	task automatic idle();
		if (slow != 0) repeat ($urandom_range(3, 1)) @(posedge ref_clk);
	endtask
	// low byte first; a block carries its count byte ahead of the mask bytes
	task automatic wr(input logic [7:0] code, input int n, input logic [63:0] data);
		@(posedge ref_clk);
		tx_start <= 1'b1;
		tx_code <= code;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			tx_start <= 1'b0;
			tx_code <= ~code;
			wr_valid <= 1'b1;
			wr_byte <= data[8*i +: 8];
			if (slow != 0) begin
				@(posedge ref_clk);
				wr_valid <= 1'b0;
				// stale byte is inverted so a late sample cannot pass
				wr_byte <= ~data[8*i +: 8];
				idle();
			end
		end
		@(posedge ref_clk);
		{tx_start, wr_valid} <= 2'b00;
		tx_end <= 1'b1;
		@(posedge ref_clk);
		tx_end <= 1'b0;
	endtask
	// bytes not read stay all ones in the returned word
	task automatic rd(input logic [7:0] code, input int n, output logic [63:0] data);
		bit got;
		data = '1;
		@(posedge ref_clk);
		tx_start <= 1'b1;
		tx_code <= code;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			tx_start <= 1'b0;
			rd_req <= 1'b1;
			@(posedge ref_clk);
			rd_req <= 1'b0;
			got = 0;
			for (int k = 0; k < 4 && !got; k++) begin
				@(posedge ref_clk);
				got = rd_valid === 1'b1;
			end
			if (!got) to_count++;
			data[8*i +: 8] = rd_byte;
			idle();
		end
	endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import ovuvf_pkg::*;
	logic ref_clk, resetn, ce, tx_start, tx_end, wr_valid, rd_req, rd_valid, lowside_on;
	logic [7:0] tx_code, wr_byte, rd_byte, c;
	logic pec_fail, protected_wr, comm_fault_other, clear_status, sample_valid, ov_viol, uv_viol;
	logic temp_valid, temp_report_valid, voltage_monitor_valid, sync_en, sync_clk_pin, alert_output;
	logic [15:0] temp_meas, temp_report, voltage_monitor, voltage_monitor_uv_limit, voltage_monitor_ov_limit, s, o, t;
	logic [55:0] status_in, status_image, m;
	logic [63:0] d;
	int n_errors = 0;
	int cmp_count = 0;
	int bits[16] = '{55, 54, 53, 52, 51, 50, 49, 48, 39, 38, 37, 33, 27, 26, 25, 7};
	int vv[4] = '{1099, 1100, 951, 950};
	int ul[4] = '{1000, 1000, 100, 100};
	int ol[4] = '{4000, 4000, 1000, 1000};
	logic [1:0] ew[4] = '{2'b10, 2'b00, 2'b01, 2'b00};
	logic [7:0] cf[3] = '{8'h0F, 8'h80, 8'h80};
	logic ovt[3] = '{1'b1, 1'b0, 1'b1};

	ovuvf_top i_ovuvf_top (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .tx_start(tx_start),
		.tx_code(tx_code), .tx_end(tx_end), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
		.rd_valid(rd_valid), .rd_byte(rd_byte), .pec_fail(pec_fail), .protected_wr(protected_wr),
		.comm_fault_other(comm_fault_other), .clear_status(clear_status), .sample_valid(sample_valid),
		.ov_viol(ov_viol), .uv_viol(uv_viol), .lowside_on(lowside_on), .temp_valid(temp_valid),
		.temp_meas(temp_meas), .temp_report_valid(temp_report_valid), .temp_report(temp_report),
		.voltage_monitor_valid(voltage_monitor_valid), .voltage_monitor(voltage_monitor), .voltage_monitor_uv_limit(voltage_monitor_uv_limit),
		.voltage_monitor_ov_limit(voltage_monitor_ov_limit), .sync_en(sync_en), .sync_clk_pin(sync_clk_pin),
		.status_in(status_in), .status_image(status_image), .alert_output(alert_output));
	ovuvf_host i_ovuvf_host (.ref_clk(ref_clk), .tx_start(tx_start), .tx_code(tx_code), .tx_end(tx_end),
		.wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req), .rd_valid(rd_valid), .rd_byte(rd_byte));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [55:0] one(input int b);
		return 56'h1 << b;
	endfunction
	function automatic logic [15:0] temp_exp(input logic [15:0] meas, input logic [15:0] sc, input logic [15:0] off);
		return meas / sc + off;
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// one-cycle pulse on a fault input; 3 clears the sticky flags
	task automatic evt(input int k);
		@(posedge ref_clk);
		pec_fail <= k == 0;
		protected_wr <= k == 1;
		comm_fault_other <= k == 2;
		clear_status <= k == 3;
		@(posedge ref_clk);
		{pec_fail, protected_wr, comm_fault_other, clear_status} <= 4'h0;
	endtask
	task automatic viol(input logic ov, input logic uv, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			sample_valid <= 1'b1;
			ov_viol <= ov;
			uv_viol <= uv;
			@(posedge ref_clk);
			sample_valid <= 1'b0;
		end
	endtask
	task automatic test_done();
		n_errors += i_ovuvf_host.to_count;
		$display("counts: compares=%0d mismatches=%0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge ref_clk);
		n_errors++;
		test_done();
	end

	initial begin
		{resetn, pec_fail, protected_wr, comm_fault_other, clear_status, sample_valid} = 6'h0;
		{ov_viol, uv_viol, temp_valid, voltage_monitor_valid, sync_en, sync_clk_pin} = 6'h0;
		temp_meas = 16'h0000;
		{voltage_monitor, voltage_monitor_uv_limit, voltage_monitor_ov_limit} = 48'h0;
		status_in = '0;
		ce = 1'b1;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		void'($urandom(32'h4490));
		i_ovuvf_host.rd(CMD_OVUV_CFG, 1, d);
		chk(d[7:0], 8'h00);
		i_ovuvf_host.rd(CMD_TEMP_SCALE, 2, d);
		chk(d[15:0], 16'h0001);
		i_ovuvf_host.rd(CMD_TEMP_OFFSET, 2, d);
		chk(d[15:0], 16'h0000);
		i_ovuvf_host.rd(CMD_ALERT_MASK, LEN_BLOCK, d);
		chk(d, 64'h07);
		$display("test reset values done");
		for (int r = 0; r < 4; r++) begin
			i_ovuvf_host.slow = r % 2;
			c = 8'($urandom);
			s = 16'($urandom);
			o = 16'($urandom);
			m = 56'({$urandom, $urandom});
			i_ovuvf_host.wr(CMD_OVUV_CFG, LEN_BYTE, {56'h0, c});
			i_ovuvf_host.wr(CMD_TEMP_SCALE, LEN_WORD, {48'h0, s});
			i_ovuvf_host.wr(CMD_TEMP_OFFSET, LEN_WORD, {48'h0, o});
			i_ovuvf_host.wr(CMD_ALERT_MASK, LEN_BLOCK, {m, 8'h07});
			i_ovuvf_host.rd(CMD_OVUV_CFG, 1, d);
			chk(d[7:0], c);
			i_ovuvf_host.rd(CMD_TEMP_SCALE, 2, d);
			chk(d[15:0], s);
			i_ovuvf_host.rd(CMD_TEMP_OFFSET, 2, d);
			chk(d[15:0], o);
			i_ovuvf_host.rd(CMD_ALERT_MASK, LEN_BLOCK, d);
			chk(d, {m, 8'h07});
		end
		i_ovuvf_host.slow = 0;
		$display("test register readback done");
		i_ovuvf_host.wr(CMD_ALERT_MASK, LEN_BLOCK, 64'h07);
		for (int k = 0; k < 3; k++) begin
			evt(3);
			tick(2);
			evt(k);
			tick(3);
			chk(status_image[k == 0 ? ST_PEC_FAIL : ST_OTHER_COMM], 1'b1);
			chk(alert_output, 1'b1);
		end
		evt(3);
		i_ovuvf_host.wr(8'h55, LEN_BYTE, 64'h0);
		tick(3);
		chk(status_image[ST_INV_CMD], 1'b1);
		evt(3);
		i_ovuvf_host.wr(CMD_ALERT_MASK, 6, 64'hFFFF_FFFF_FF07);
		tick(3);
		chk(status_image[ST_INV_DATA], 1'b1);
		i_ovuvf_host.rd(CMD_ALERT_MASK, LEN_BLOCK, d);
		chk(d, 64'h07);
		// a fault pulse while the clock enable is low must leave no trace
		ce <= 1'b0;
		evt(0);
		ce <= 1'b1;
		tick(3);
		chk({status_image[ST_PEC_FAIL], alert_output}, 2'b01);
		$display("test comm faults done");
		for (int k = 0; k < 3; k++) begin
			c = cf[k];
			if (k == 1) c[3:0] = 4'($urandom_range(15, 0));
			i_ovuvf_host.wr(CMD_OVUV_CFG, LEN_BYTE, {56'h0, c});
			evt(3);
			tick(2);
			viol(ovt[k], !ovt[k], c[3:0]);
			viol(1'b0, 1'b0, 1);
			viol(ovt[k], !ovt[k], c[3:0]);
			tick(3);
			chk({status_image[ST_VOUT_OV], status_image[ST_VOUT_UV], lowside_on}, 3'b000);
			viol(ovt[k], !ovt[k], 1);
			tick(3);
			chk({status_image[ST_VOUT_OV], status_image[ST_VOUT_UV], lowside_on}, {ovt[k], !ovt[k], ovt[k] & c[7]});
		end
		$display("test debounce done");
		for (int i = 0; i < 4; i++) begin
			s = (i == 0) ? 16'h0001 : 16'($urandom_range(300, 2));
			o = (i == 0) ? 16'h0001 : 16'($urandom);
			t = (i == 0) ? 16'hFFFF : 16'($urandom);
			i_ovuvf_host.wr(CMD_TEMP_SCALE, LEN_WORD, {48'h0, s});
			i_ovuvf_host.wr(CMD_TEMP_OFFSET, LEN_WORD, {48'h0, o});
			@(posedge ref_clk);
			temp_valid <= 1'b1;
			temp_meas <= t;
			@(posedge ref_clk);
			temp_valid <= 1'b0;
			for (int k = 0; k < 40 && temp_report_valid !== 1'b1; k++) @(posedge ref_clk);
			chk(temp_report_valid, 1'b1);
			chk(temp_report, temp_exp(t, s, o));
		end
		$display("test temperature done");
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			voltage_monitor_valid <= 1'b1;
			voltage_monitor <= 16'(vv[i]);
			voltage_monitor_uv_limit <= 16'(ul[i]);
			voltage_monitor_ov_limit <= 16'(ol[i]);
			@(posedge ref_clk);
			voltage_monitor_valid <= 1'b0;
			tick(3);
			chk({status_image[ST_VOLTAGE_MONITOR_UV_WARN], status_image[ST_VOLTAGE_MONITOR_OV_WARN]}, ew[i]);
		end
		$display("test monitor warnings done");
		@(posedge ref_clk);
		sync_en <= 1'b1;
		evt(3);
		repeat (60) begin
			tick(5);
			sync_clk_pin <= ~sync_clk_pin;
		end
		chk(status_image[ST_TSW_FLT], 1'b0);
		tick(215);
		chk(status_image[ST_TSW_FLT], 1'b1);
		sync_en <= 1'b0;
		evt(3);
		$display("test sync loss done");
		// each bit alone: blocked by its own mask bit, passed when every other bit is masked
		for (int i = 0; i < 16; i++) begin
			i_ovuvf_host.slow = i % 2;
			i_ovuvf_host.wr(CMD_ALERT_MASK, LEN_BLOCK, {one(bits[i]), 8'h07});
			@(posedge ref_clk);
			status_in <= one(bits[i]);
			tick(3);
			chk(alert_output, 1'b0);
			chk(status_image, one(bits[i]));
			i_ovuvf_host.wr(CMD_ALERT_MASK, LEN_BLOCK, {~one(bits[i]), 8'h07});
			tick(3);
			chk(alert_output, 1'b1);
			@(posedge ref_clk);
			status_in <= '0;
			tick(3);
			chk(alert_output, 1'b0);
		end
		$display("test alert mask done");
		test_done();
	end
endmodule
